/* rtl/sbp_device.sv */
// device end: strobe, acknowledge, arbitration and interrupt pin control
//
// Design decisions made here: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
// Summary of operation
// [R1] address strobe driven only while device masters
// [R2] read/write driven when master, released otherwise; the device never reads rw_x
// [R3] 16-bit: upper strobe; 8-bit: address bit zero
// [R4] 16-bit: lower strobe; 8-bit: single strobe
// [R5] internal acknowledge: own cycles on-chip, or programmed range with ack_internal_cs_in; outside masters on-chip, or any address with ack_internal_cs_in
// [R6] outside logic acknowledges other external accesses
// [R7] indivisible output held through read-modify-write
// [R8] core disabled: pins carry interrupt code bits
// [R9] internal access flag for on-chip targets
// [R10] no internal access for serial dma hits
// [R11] internal access timed like chip selects
// [R12] bus clear asks outside master to release
// [R13] core disabled: bus clear also independent_dma input
// [R14] bus request input, or open-drain when disabled
// [R15] grant drive, disabled input, follows request in reset
// [R16] grant acknowledge driven while dma engines own
// [R17] outside masters should use grant acknowledge
// [R18] priority inputs decoded binary, seven nonmaskable
// [R19] outside interrupter holds priority until acknowledge
// [R20] dedicated mode: separate requests one, six, seven
// [R21] cycle type codes driven with strobe as master
// [R22] autovector replaces acknowledge during interrupt acknowledge
// [R23] bus width fixed except during total reset
module sbp_device #(
   parameter int unsigned ACK_WAIT = 2
) (
   input wire logic clock_in,
   input wire logic rst_in,
   sbp_if.dev pins,
   input wire logic bus_width_select_in,
   input wire logic core_disable_in,
   input wire logic dedicated_irq_in,
   input wire logic [1:0] edge_mode_in,
   input wire logic ack_internal_cs_in,
   input wire logic [23:0] cs_base_in,
   input wire logic [23:0] cs_mask_in,
   input wire logic req_valid_in,
   input wire logic [1:0] req_master_in,
   input wire logic [23:0] req_addr_in,
   input wire logic req_write_in,
   input wire logic [1:0] req_bytes_in,
   input wire logic req_rmw_in,
   input wire logic [2:0] req_fc_in,
   input wire logic [2:0] irq_code_in,
   input wire logic bus_clear_req_in,
   output logic req_done_out,
   output logic req_autovec_out,
   output logic master_out,
   output logic ext_master_out,
   output logic [2:0] irq_level_out,
   output logic irq_nmi_pulse_out,
   output logic release_req_out,
   output logic bus_width16_out
);
   sbp_pkg::sbp_cyc_t st_q;
   logic [7:0] wait_q;
   logic own_q, rmw_q, bw_q, ext_as_q, iac_q, ext_hit_q;
   logic [1:0] mst_q;
   logic [23:0] addr_q;
   logic wr_q;
   logic [1:0] bytes_q;
   logic [2:0] fc_q;
   logic [2:0] irq_hist_q;
   logic int_hit, cs_hit, self_ack, iack;
   logic [23:0] ext_a;

   assign ext_a = pins.addr_xe ? pins.addr_x : 24'h000000;
   function automatic logic on_chip(input logic [23:0] a);
      on_chip = (a[23:sbp_pkg::INT_SPAN_BITS] == sbp_pkg::INT_BASE_RESET[23:sbp_pkg::INT_SPAN_BITS]) ||
         (a >= sbp_pkg::CFG_LO && a <= sbp_pkg::CFG_HI);
   endfunction
   assign int_hit = on_chip(addr_q);
   assign cs_hit = ((addr_q & cs_mask_in) == (cs_base_in & cs_mask_in));
   assign self_ack = int_hit || (cs_hit && ack_internal_cs_in); // [R5]
   assign iack = (fc_q == sbp_pkg::FC_CPU_SPACE);

   // width strap caught during reset only
   always_ff @(posedge clock_in)
   begin
      bw_q <= rst_in ? bus_width_select_in : bw_q; // [R23]
   end
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
         bus_width16_out <= 1'b0;
      else
         bus_width16_out <= bw_q; // [R23]
   end

   // own bus cycle sequencer
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         st_q <= sbp_pkg::SBP_IDLE;
         own_q <= 1'b0;
         mst_q <= sbp_pkg::MST_NONE;
         addr_q <= 24'h000000;
         wr_q <= 1'b0;
         bytes_q <= 2'h0;
         rmw_q <= 1'b0;
         fc_q <= 3'h0;
         wait_q <= 8'h00;
         req_done_out <= 1'b0;
         req_autovec_out <= 1'b0;
      end
      else
      begin
         req_done_out <= 1'b0;
         req_autovec_out <= 1'b0;
         case (st_q)
            sbp_pkg::SBP_IDLE:
            begin
               // the request that just finished is still held in the done cycle
               if (req_valid_in && !req_done_out && !ext_master_out && req_master_in != sbp_pkg::MST_NONE)
               begin
                  st_q <= sbp_pkg::SBP_ADDR;
                  own_q <= 1'b1;
                  mst_q <= req_master_in;
                  addr_q <= req_addr_in;
                  wr_q <= req_write_in;
                  bytes_q <= req_bytes_in;
                  rmw_q <= req_rmw_in;
                  fc_q <= req_fc_in;
                  wait_q <= 8'h00;
               end
               else if (!req_valid_in)
               begin
                  own_q <= 1'b0;
                  rmw_q <= 1'b0;
               end
            end
            sbp_pkg::SBP_ADDR:
               st_q <= sbp_pkg::SBP_DATA;
            sbp_pkg::SBP_DATA:
            begin
               wait_q <= wait_q + 8'h01;
               if (iack && !pins.autovector_in_x) // [R22]
                  st_q <= sbp_pkg::SBP_DONE;
               else if (self_ack ? (wait_q >= 8'(ACK_WAIT)) : (pins.ack_xe && !pins.ack_x)) // [R6]
                  st_q <= sbp_pkg::SBP_DONE;
            end
            sbp_pkg::SBP_DONE:
            begin
               req_done_out <= 1'b1;
               req_autovec_out <= iack && !pins.autovector_in_x; // [R22]
               st_q <= sbp_pkg::SBP_IDLE;
               if (!(rmw_q && req_valid_in && req_rmw_in)) // [R7]
               begin
                  own_q <= 1'b0;
                  rmw_q <= 1'b0;
               end
            end
            default:
               st_q <= sbp_pkg::SBP_IDLE;
         endcase
      end
   end

   // pin drive from device cycle
   always_comb
   begin
      pins.as_oe = own_q; // [R1]
      pins.as_o = !(st_q == sbp_pkg::SBP_DATA || st_q == sbp_pkg::SBP_DONE);
      pins.rw_oe = own_q; // [R2]
      pins.rw_o = !wr_q;
      pins.addr_oe = own_q;
      pins.addr_o = addr_q;
      pins.fc_oe = own_q; // [R21]
      pins.fc_o = fc_q;
      pins.uds_oe = own_q;
      pins.lds_oe = own_q;
      if (bus_width16_out)
      begin
         pins.uds_o = pins.as_o || !bytes_q[1]; // [R3]
         pins.lds_o = pins.as_o || !bytes_q[0]; // [R4]
      end
      else
      begin
         pins.uds_o = addr_q[0]; // [R3]
         pins.lds_o = pins.as_o; // [R4]
      end
      pins.ack_oe = (own_q && self_ack) || (ext_as_q && (ext_hit_q || ack_internal_cs_in)); // [R5]
      pins.ack_o = !(st_q == sbp_pkg::SBP_DONE || ext_as_q);
      pins.rmc_o = core_disable_in ? irq_code_in[1] : !(own_q && rmw_q); // [R7] [R8]
      pins.iout_o = core_disable_in ? irq_code_in : 3'h7; // [R8]
      pins.iac_o = iac_q; // [R9]
      pins.bus_clear_oe = bus_clear_req_in || (req_valid_in && req_master_in == sbp_pkg::MST_SERIAL_DMA); // [R12]
      pins.br_oe = core_disable_in && req_valid_in && !master_out; // [R14]
      pins.bg_oe = !core_disable_in; // [R15]
      // no grant while an own request waits, so both ends never start together
      pins.bg_o = rst_in ? pins.br_x :
         !(pins.br_x == 1'b0 && st_q == sbp_pkg::SBP_IDLE && !own_q && !req_valid_in); // [R15]
      pins.grant_acknowledge_oe = own_q && mst_q != sbp_pkg::MST_CORE; // [R16]
      pins.grant_acknowledge_o = 1'b0;
   end

   // internal access flag: same timing as chip selects
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         iac_q <= 1'b0;
         ext_as_q <= 1'b0;
         ext_hit_q <= 1'b0;
      end
      else
      begin
         ext_as_q <= !own_q && pins.as_xe && !pins.as_x;
         ext_hit_q <= on_chip(ext_a);
         if (own_q)
            iac_q <= int_hit && mst_q != sbp_pkg::MST_SERIAL_DMA; // [R9] [R10] [R11]
         else
            iac_q <= pins.as_xe && !pins.as_x && on_chip(ext_a); // [R9]
      end
   end

   // interrupt input decode
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         irq_hist_q <= 3'h7;
         irq_level_out <= sbp_pkg::IPL_NONE;
         irq_nmi_pulse_out <= 1'b0;
         master_out <= 1'b0;
         ext_master_out <= 1'b0;
         release_req_out <= 1'b0;
      end
      else
      begin
         irq_hist_q <= pins.ipl_x;
         master_out <= own_q;
         ext_master_out <= (pins.grant_acknowledge_xe && !pins.grant_acknowledge_x && !own_q); // [R17]
         release_req_out <= core_disable_in && !pins.bus_clear_x; // [R13]
         if (!dedicated_irq_in)
         begin
            irq_level_out <= ~pins.ipl_x; // [R18]
            irq_nmi_pulse_out <= (~pins.ipl_x == sbp_pkg::IPL_NMI) && (~irq_hist_q != sbp_pkg::IPL_NMI);
         end
         else
         begin
            // [R20] level 7 always edge; 1 and 6 per edge_mode_in
            irq_nmi_pulse_out <= !pins.ipl_x[2] && irq_hist_q[2];
            if (!pins.ipl_x[1] && (!edge_mode_in[1] || irq_hist_q[1]))
               irq_level_out <= 3'h6;
            else if (!pins.ipl_x[0] && (!edge_mode_in[0] || irq_hist_q[0]))
               irq_level_out <= 3'h1;
            else
               irq_level_out <= sbp_pkg::IPL_NONE;
         end
      end
   end
endmodule
`default_nettype wire

/* rtl/sbp_if.sv */
// interface: pin bundle between the device and the outside party
`timescale 1ns/10ps
`default_nettype none
interface sbp_if;
   // device-driven pins (value and enable)
   logic as_o, as_oe, rw_o, rw_oe, uds_o, uds_oe, lds_o, lds_oe;
   logic ack_o, ack_oe, rmc_o, bus_clear_oe, iac_o, bg_o, bg_oe, grant_acknowledge_o, grant_acknowledge_oe, br_oe;
   logic [2:0] fc_o, iout_o;
   logic fc_oe;
   logic [23:0] addr_o;
   logic addr_oe;
   // far-end driven pins
   logic as_x, as_xe, rw_x, rw_xe, uds_x, uds_xe, lds_x, lds_xe, ack_x, ack_xe;
   logic br_x, bg_x, grant_acknowledge_x, grant_acknowledge_xe, bus_clear_x, autovector_in_x;
   logic [2:0] fc_x, ipl_x;
   logic fc_xe;
   logic [23:0] addr_x;
   logic addr_xe;
   modport dev (
      output as_o, as_oe, rw_o, rw_oe, uds_o, uds_oe, lds_o, lds_oe, ack_o, ack_oe, rmc_o, bus_clear_oe,
      output iac_o, bg_o, bg_oe, grant_acknowledge_o, grant_acknowledge_oe, br_oe, fc_o, iout_o, fc_oe, addr_o, addr_oe,
      input as_x, as_xe, rw_x, rw_xe, uds_x, uds_xe, lds_x, lds_xe, ack_x, ack_xe,
      input br_x, bg_x, grant_acknowledge_x, grant_acknowledge_xe, bus_clear_x, autovector_in_x, fc_x, ipl_x, fc_xe, addr_x, addr_xe
   );
   modport ext (
      input as_o, as_oe, rw_o, rw_oe, uds_o, uds_oe, lds_o, lds_oe, ack_o, ack_oe, rmc_o, bus_clear_oe,
      input iac_o, bg_o, bg_oe, grant_acknowledge_o, grant_acknowledge_oe, br_oe, fc_o, iout_o, fc_oe, addr_o, addr_oe,
      output as_x, as_xe, rw_x, rw_xe, uds_x, uds_xe, lds_x, lds_xe, ack_x, ack_xe,
      output br_x, bg_x, grant_acknowledge_x, grant_acknowledge_xe, bus_clear_x, autovector_in_x, fc_x, ipl_x, fc_xe, addr_x, addr_xe
   );
endinterface
`default_nettype wire

/* rtl/sbp_outside.sv */
// outside end: external master, interrupter and acknowledge logic
`timescale 1ns/10ps
`default_nettype none
module sbp_outside (
   input wire logic clock_in,
   input wire logic rst_in,
   sbp_if.ext pins,
   input wire logic want_bus_in,
   input wire logic [23:0] addr_in,
   input wire logic write_in,
   input wire logic [2:0] ipl_level_in,
   input wire logic use_autovector_in_in,
   input wire logic ext_ack_in,
   output logic granted_out,
   output logic cycle_seen_out,
   output logic iac_seen_out,
   output logic release_out
);
   logic own_q, as_q;
   always_ff @(posedge clock_in or posedge rst_in)
   begin
      if (rst_in)
      begin
         own_q <= 1'b0;
         as_q <= 1'b0;
         granted_out <= 1'b0;
         cycle_seen_out <= 1'b0;
         iac_seen_out <= 1'b0;
         release_out <= 1'b0;
      end
      else
      begin
         // [R17] take bus only after grant, then hold grant acknowledge
         if (want_bus_in && !pins.bg_o && !pins.grant_acknowledge_oe && pins.as_o)
            own_q <= 1'b1;
         else if (!want_bus_in && !as_q)
            own_q <= 1'b0;
         as_q <= own_q && want_bus_in && !as_q;
         granted_out <= own_q;
         cycle_seen_out <= pins.as_oe && !pins.as_o;
         iac_seen_out <= pins.iac_o;
         release_out <= pins.bus_clear_oe; // [R12]
      end
   end
   always_comb
   begin
      pins.br_x = !(want_bus_in && !own_q); // [R14]
      pins.grant_acknowledge_x = 1'b0;
      pins.grant_acknowledge_xe = own_q; // [R17]
      pins.as_x = !as_q;
      pins.as_xe = own_q;
      pins.rw_x = !write_in;
      pins.rw_xe = own_q;
      pins.uds_x = !as_q;
      pins.uds_xe = own_q;
      pins.lds_x = !as_q;
      pins.lds_xe = own_q;
      pins.addr_x = addr_in;
      pins.addr_xe = own_q;
      pins.fc_x = sbp_pkg::FC_CORE_DATA;
      pins.fc_xe = own_q;
      pins.ipl_x = ~ipl_level_in; // [R19]
      pins.autovector_in_x = !(use_autovector_in_in && pins.fc_o == sbp_pkg::FC_CPU_SPACE && !pins.as_o); // [R22]
      pins.ack_x = !(ext_ack_in && !pins.as_o && !use_autovector_in_in); // [R6]
      pins.ack_xe = !pins.ack_oe && pins.as_oe;
      pins.bg_x = 1'b1;
      pins.bus_clear_x = 1'b1; // [R13]
   end
endmodule
`default_nettype wire

/* rtl/sbp_pkg.sv */
// package: constants and types for the system bus pin control link
package sbp_pkg;
   localparam int unsigned ADDR_W = 24;
   localparam int unsigned FC_W = 3;
   localparam int unsigned IPL_W = 3;
   // internal block base, 4K span, config register window
   localparam logic [23:0] INT_BASE_RESET = 24'h000000;
   localparam int unsigned INT_SPAN_BITS = 12;
   localparam logic [23:0] CFG_LO = 24'h0000f0;
   localparam logic [23:0] CFG_HI = 24'h0000ff;
   // cycle type code used by the core for interrupt acknowledge
   localparam logic [2:0] FC_CPU_SPACE = 3'h7;
   localparam logic [2:0] FC_CORE_DATA = 3'h5;
   localparam logic [2:0] IPL_NMI = 3'h7;
   localparam logic [2:0] IPL_NONE = 3'h0;
   // master select encoding
   localparam logic [1:0] MST_NONE = 2'h0;
   localparam logic [1:0] MST_CORE = 2'h1;
   localparam logic [1:0] MST_SERIAL_DMA = 2'h2;
   localparam logic [1:0] MST_INDEPENDENT_DMA = 2'h3;
   typedef enum logic [1:0] {
      SBP_IDLE = 2'b00,
      SBP_ADDR = 2'b01,
      SBP_DATA = 2'b11,
      SBP_DONE = 2'b10
   } sbp_cyc_t;
endpackage

/* verif/sbp_sva.sv */
// checker: pin-level relations across the link
`timescale 1ns/10ps
`default_nettype none
module sbp_sva (
   input wire logic clock_in,
   input wire logic rst_in,
   input wire logic as_o,
   input wire logic as_oe,
   input wire logic as_xe,
   input wire logic rw_oe,
   input wire logic rw_xe,
   input wire logic uds_o,
   input wire logic uds_oe,
   input wire logic [23:0] addr_o,
   input wire logic addr_oe,
   input wire logic ack_oe,
   input wire logic ack_xe,
   input wire logic grant_acknowledge_oe,
   input wire logic grant_acknowledge_xe,
   input wire logic [2:0] fc_o,
   input wire logic fc_oe,
   input wire logic autovector_in_x
);
   default clocking cb @(posedge clock_in); endclocking
   default disable iff (rst_in);
   property p_as_excl;
      !(as_oe && as_xe);
   endproperty
   a_as_excl: assert property (p_as_excl) else $error("strobe driven by both ends");
   property p_as_low;
      $rose(as_oe) |=> !as_o;
   endproperty
   a_as_low: assert property (p_as_low) else $error("strobe not low after address phase");
   property p_rw;
      rw_oe |-> !rw_xe;
   endproperty
   a_rw: assert property (p_rw) else $error("direction line driven by both ends");
   property p_a0;
      as_oe && !as_o && uds_oe |-> uds_o == addr_o[0];
   endproperty
   a_a0: assert property (p_a0) else $error("upper pin differs from address bit zero");
   property p_ack;
      ack_xe |-> !ack_oe;
   endproperty
   a_ack: assert property (p_ack) else $error("acknowledge driven by both ends");
   property p_grant_acknowledge;
      grant_acknowledge_oe |-> !grant_acknowledge_xe;
   endproperty
   a_grant_acknowledge: assert property (p_grant_acknowledge) else $error("grant acknowledge driven by both ends");
   property p_fc;
      as_oe && !as_o |-> fc_oe && addr_oe;
   endproperty
   a_fc: assert property (p_fc) else $error("codes or address not driven with strobe");
   property p_autovector_in;
      $fell(autovector_in_x) |-> fc_oe && fc_o == sbp_pkg::FC_CPU_SPACE;
   endproperty
   a_autovector_in: assert property (p_autovector_in) else $error("autovector outside acknowledge cycle");
endmodule
`default_nettype wire

/* verif/system_bus_pin_control_tb.sv */
// testbench: device and outside end joined through the pin interface
`timescale 1ns/10ps
`default_nettype none
module system_bus_pin_control_tb;
   localparam int ACK_WAIT = 2;
   logic clock_in = 1'b0, rst_in = 1'b1;
   logic req_valid = 1'b0, req_write = 1'b0, req_rmw = 1'b0, bus_clear_req = 1'b0, ack_cs = 1'b0;
   logic [1:0] req_master = 2'h0;
   logic [23:0] req_addr = 24'h000000, cs_base = 24'h100000, cs_mask = 24'hff0000;
   logic [2:0] req_fc = 3'h0, irq_code = 3'h0, ipl = 3'h0;
   logic want_bus = 1'b0, o_write = 1'b0, use_autovector_in = 1'b0, ext_ack = 1'b1;
   logic [23:0] o_addr = 24'h000100;
   logic done, autovec, master, ext_master, nmi, rel_req, bw16, granted, cyc_seen, iac_seen, rel;
   logic [2:0] irq_level;
   logic av = 1'b0;
   logic [3:0] seen = 4'h0;
   int n_errors = 0, checked = 0, cycles = 0, n, n_nmi = 0, n_ext_ack = 0;
   sbp_if sbp_if_i ();
   sbp_device #(.ACK_WAIT(ACK_WAIT)) sbp_device_i (.clock_in(clock_in), .rst_in(rst_in), .pins(sbp_if_i),
      .bus_width_select_in(1'b0), .core_disable_in(1'b0), .dedicated_irq_in(1'b0), .edge_mode_in(2'h0),
      .ack_internal_cs_in(ack_cs), .cs_base_in(cs_base), .cs_mask_in(cs_mask), .req_valid_in(req_valid),
      .req_master_in(req_master), .req_addr_in(req_addr), .req_write_in(req_write), .req_bytes_in(2'h1),
      .req_rmw_in(req_rmw), .req_fc_in(req_fc), .irq_code_in(irq_code), .bus_clear_req_in(bus_clear_req),
      .req_done_out(done), .req_autovec_out(autovec), .master_out(master), .ext_master_out(ext_master),
      .irq_level_out(irq_level), .irq_nmi_pulse_out(nmi), .release_req_out(rel_req), .bus_width16_out(bw16));
   sbp_outside sbp_outside_i (.clock_in(clock_in), .rst_in(rst_in), .pins(sbp_if_i), .want_bus_in(want_bus),
      .addr_in(o_addr), .write_in(o_write), .ipl_level_in(ipl), .use_autovector_in_in(use_autovector_in), .ext_ack_in(ext_ack),
      .granted_out(granted), .cycle_seen_out(cyc_seen), .iac_seen_out(iac_seen), .release_out(rel));
   sbp_sva sbp_sva_i (.clock_in(clock_in), .rst_in(rst_in), .as_o(sbp_if_i.as_o), .as_oe(sbp_if_i.as_oe),
      .as_xe(sbp_if_i.as_xe), .rw_oe(sbp_if_i.rw_oe), .rw_xe(sbp_if_i.rw_xe), .uds_o(sbp_if_i.uds_o),
      .uds_oe(sbp_if_i.uds_oe), .addr_o(sbp_if_i.addr_o), .addr_oe(sbp_if_i.addr_oe), .ack_oe(sbp_if_i.ack_oe),
      .ack_xe(sbp_if_i.ack_xe), .grant_acknowledge_oe(sbp_if_i.grant_acknowledge_oe), .grant_acknowledge_xe(sbp_if_i.grant_acknowledge_xe),
      .fc_o(sbp_if_i.fc_o), .fc_oe(sbp_if_i.fc_oe), .autovector_in_x(sbp_if_i.autovector_in_x));
   always #5 clock_in = ~clock_in;
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checked++;
      if (got !== exp)
      begin
         n_errors++;
         $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop();
      $display("errors %0d, checks %0d", n_errors, checked);
      if (n_errors == 0 && checked > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask
   // one device cycle; n = negedges until done, seen = {master, strobe seen, iac, grant_acknowledge enable}
   task automatic dev_cycle(input logic [1:0] m, input logic [23:0] a, input logic w, input logic [2:0] fc);
      @(posedge clock_in);
      req_valid <= 1'b1;
      req_master <= m;
      req_addr <= a;
      req_write <= w;
      req_fc <= fc;
      n = 0;
      seen = 4'h0;
      do
      begin
         @(negedge clock_in);
         n++;
         // first sample may still show the previous cycle
         if (n > 1)
            seen = seen | {master, cyc_seen, sbp_if_i.iac_o, sbp_if_i.grant_acknowledge_oe};
      end
      while (done !== 1'b1 && n < 40);
      av = autovec;
      @(posedge clock_in);
      req_valid <= 1'b0;
   endtask
   // bounded wait for a flag
   task automatic wait_flag(ref logic f);
      n = 0;
      while (f !== 1'b1 && n < 40)
      begin
         @(negedge clock_in);
         n++;
      end
      chk(f, 1'b1);
   endtask
   always @(posedge clock_in)
   begin
      cycles++;
      if (nmi === 1'b1)
         n_nmi++;
      if (ext_master === 1'b1 && sbp_if_i.ack_oe === 1'b1)
         n_ext_ack++;
      if (cycles == 5000)
      begin
         n_errors++;
         report_and_stop();
      end
   end
   initial
   begin
      repeat (2) @(posedge clock_in);
      #1;
      chk(sbp_if_i.bg_o, sbp_if_i.br_x);
      chk(sbp_if_i.as_oe, 1'b0);
      @(posedge clock_in);
      rst_in <= 1'b0;
      dev_cycle(sbp_pkg::MST_CORE, 24'h000010, 1'b0, sbp_pkg::FC_CORE_DATA);
      chk(n, ACK_WAIT + 5);
      chk(seen, 4'he);
      chk(bw16, 1'b0);
      dev_cycle(sbp_pkg::MST_INDEPENDENT_DMA, sbp_pkg::CFG_LO + 24'h000004, 1'b1, 3'h1);
      chk(n, ACK_WAIT + 5);
      chk(seen, 4'hf);
      req_rmw <= 1'b1;
      fork
         dev_cycle(sbp_pkg::MST_CORE, 24'h000020, 1'b0, sbp_pkg::FC_CORE_DATA);
         begin
            repeat (3) @(negedge clock_in);
            chk(sbp_if_i.rmc_o, 1'b0);
         end
      join
      req_rmw <= 1'b0;
      dev_cycle(sbp_pkg::MST_CORE, 24'h200000, 1'b0, sbp_pkg::FC_CORE_DATA);
      chk(n, 5);
      chk(seen, 4'hc);
      chk(av, 1'b0);
      ack_cs <= 1'b1;
      dev_cycle(sbp_pkg::MST_SERIAL_DMA, 24'h100002, 1'b1, 3'h2);
      chk(n, ACK_WAIT + 5);
      chk(seen, 4'hd);
      dev_cycle(sbp_pkg::MST_SERIAL_DMA, 24'h000040, 1'b0, 3'h2);
      chk(n, ACK_WAIT + 5);
      chk(seen, 4'hd);
      use_autovector_in <= 1'b1;
      ipl <= sbp_pkg::IPL_NMI;
      dev_cycle(sbp_pkg::MST_CORE, 24'hff0000, 1'b0, sbp_pkg::FC_CPU_SPACE);
      chk(n, 5);
      chk(av, 1'b1);
      chk(irq_level, sbp_pkg::IPL_NMI);
      chk(n_nmi, 1);
      use_autovector_in <= 1'b0;
      ipl <= 3'h3;
      repeat (4) @(negedge clock_in);
      chk(irq_level, 3'h3);
      want_bus <= 1'b1;
      wait_flag(granted);
      wait_flag(ext_master);
      wait_flag(iac_seen);
      chk(n_ext_ack != 0, 1'b1);
      bus_clear_req <= 1'b1;
      wait_flag(rel);
      want_bus <= 1'b0;
      bus_clear_req <= 1'b0;
      repeat (6) @(posedge clock_in);
      dev_cycle(sbp_pkg::MST_CORE, 24'h000030, 1'b1, sbp_pkg::FC_CORE_DATA);
      chk(n, ACK_WAIT + 5);
      report_and_stop();
   end
endmodule
`default_nettype wire
